// ### src/rmcc_pkg.sv
// package for the resistance mask and common control register bank
package rmcc_pkg;
  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0] RES_MASK_OFS  = 8'h11;
  localparam logic [7:0] COMM_CTRL_OFS = 8'h15;
  localparam logic [7:0] RES_MASK_RST  = 8'h00;
  localparam logic [7:0] COMM_CTRL_RST = 8'he0;
  localparam logic [7:0] RES_MASK_WMSK = 8'h3f;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int GROUND_BIT   = 5;
  localparam int SIDEBAND_BIT = 4;
  localparam int FINITE_BIT   = 3;
  localparam int OPEN_BIT     = 2;
  localparam int ABORT_BIT    = 1;
  localparam int MOIST_BIT    = 0;
  localparam int IRQ_SEL_BIT  = 7;
  localparam int DBG_GATE_BIT = 6;
  localparam int USB_GATE_BIT = 5;
  localparam int PUMP_BIT     = 4;
  localparam int SUPPLY_BIT   = 3;
  localparam int LP_DRP_BIT   = 2;
  localparam int LP_UFP_BIT   = 1;
  localparam int SHDN_BIT     = 0;

  // ***********************************************
  // carriers
  // ***********************************************
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmcc_req_t;

  typedef struct packed {
    logic ground;
    logic sideband;
    logic finite;
    logic open_res;
    logic abort;
    logic moist;
  } rmcc_events_t;

  typedef enum logic [1:0] {
    RMCC_LP_IDLE,
    RMCC_LP_ARMED
  } rmcc_lp_state_t;
endpackage : rmcc_pkg

// ### src/rmcc_top.sv
// register bank for resistance result masking and common control
// Functional notes
// - bit5 unmasks ground result interrupt
// - bit4 unmasks sideband resistor result interrupt
// - bit3 unmasks finite invalid result interrupt
// - bit2 unmasks open result interrupt
// - bit1 unmasks aborted measurement interrupt
// - bit0 unmasks moisture result interrupt
// - control bit7 picks irq pin function
// - autoconfig starts per usb or debug gates
// - bit6 gates debug accessory trigger
// - bit5 gates usb valid trigger
// - bit4 forces switch charge pump on
// - bit3 forces internal supply to battery
// - bit2 write one triggers low power drp
// - bit1 write one triggers low power ufp
// - bit0 write one triggers shutdown
`timescale 1ns/1ps
module rmcc_top (
  input  wire logic                  ref_clk,               // 20 MHz clock
  input  wire logic                  arst_n,                // async reset, active low
  input  wire rmcc_pkg::rmcc_req_t   reg_req,               // register access request
  output logic [7:0]                 reg_rdata,             // read data, one cycle after rd_en
  output logic                       reg_rvalid,            // read data valid pulse
  input  wire rmcc_pkg::rmcc_events_t res_event,            // resistance result event pulses
  input  wire logic                  event_clear,           // clears pending events
  input  wire logic                  flag_source,           // thermal, ovp or autocfg flag
  input  wire logic                  usb_valid,             // usb valid condition
  input  wire logic                  debug_sink_entered,    // debug accessory sink entered pulse
  output logic                       irq_output_pin_n,      // irq pin, active low
  output logic                       autocfg_start,         // autoconfig start pulse
  output logic                       switch_pump_force_on,  // charge pump forced on
  output logic                       internal_supply_force_battery, // supply forced to battery
  output logic                       low_power_dual_role_request,   // lp drp entry pulse
  output logic                       low_power_upstream_request,    // lp ufp entry pulse
  output logic                       shutdown_request       // shutdown entry pulse
);

  // ***********************************************
  // registers
  // ***********************************************
  logic [7:0]              res_mask_r;
  logic [7:0]              comm_ctrl_r;
  logic [5:0]              pending_r;
  logic                    usb_valid_r;
  rmcc_pkg::rmcc_lp_state_t lp_state_r;
  logic [5:0]              ev_vec;
  logic                    wr_mask;
  logic                    wr_ctrl;

  assign ev_vec  = {res_event.ground, res_event.sideband, res_event.finite,
                    res_event.open_res, res_event.abort, res_event.moist};
  assign wr_mask = reg_req.wr_en && (reg_req.addr == rmcc_pkg::RES_MASK_OFS);
  assign wr_ctrl = reg_req.wr_en && (reg_req.addr == rmcc_pkg::COMM_CTRL_OFS);

  // ***********************************************
  // register writes and reads
  // ***********************************************
  // reserved bits dropped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_mask_r <= rmcc_pkg::RES_MASK_RST;
    end else if (wr_mask) begin
      res_mask_r <= reg_req.wdata & rmcc_pkg::RES_MASK_WMSK;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      comm_ctrl_r <= rmcc_pkg::COMM_CTRL_RST;
    end else if (wr_ctrl) begin
      comm_ctrl_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        case (reg_req.addr)
          rmcc_pkg::RES_MASK_OFS:  reg_rdata <= res_mask_r;
          rmcc_pkg::COMM_CTRL_OFS: reg_rdata <= comm_ctrl_r;
          default:                 reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ***********************************************
  // pending events and irq pin
  // ***********************************************
  // set wins over clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_r <= 6'h00;
    end else begin
      pending_r <= (event_clear ? 6'h00 : pending_r) | ev_vec;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_output_pin_n <= 1'b1;
    end else if (comm_ctrl_r[rmcc_pkg::IRQ_SEL_BIT]) begin
      irq_output_pin_n <= ~|(pending_r & res_mask_r[5:0]);
    end else begin
      irq_output_pin_n <= ~flag_source;
    end
  end

  // ***********************************************
  // autoconfiguration start
  // ***********************************************
  // usb or debug trigger
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      usb_valid_r   <= 1'b0;
      autocfg_start <= 1'b0;
    end else begin
      usb_valid_r   <= usb_valid;
      autocfg_start <= (comm_ctrl_r[rmcc_pkg::USB_GATE_BIT] && usb_valid && !usb_valid_r) ||
                       (comm_ctrl_r[rmcc_pkg::DBG_GATE_BIT] && debug_sink_entered);
    end
  end

  // ***********************************************
  // forced controls
  // ***********************************************
  // force levels
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      switch_pump_force_on          <= 1'b0;
      internal_supply_force_battery <= 1'b0;
    end else begin
      switch_pump_force_on          <= comm_ctrl_r[rmcc_pkg::PUMP_BIT];
      internal_supply_force_battery <= comm_ctrl_r[rmcc_pkg::SUPPLY_BIT];
    end
  end

  // ***********************************************
  // low power entry triggers
  // ***********************************************
  // write one triggers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_power_dual_role_request <= 1'b0;
      low_power_upstream_request  <= 1'b0;
      shutdown_request            <= 1'b0;
    end else begin
      low_power_dual_role_request <= wr_ctrl && reg_req.wdata[rmcc_pkg::LP_DRP_BIT];
      low_power_upstream_request  <= wr_ctrl && reg_req.wdata[rmcc_pkg::LP_UFP_BIT];
      shutdown_request            <= wr_ctrl && reg_req.wdata[rmcc_pkg::SHDN_BIT];
    end
  end

  // tracks whether any low power entry is requested
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_state_r <= rmcc_pkg::RMCC_LP_IDLE;
    end else begin
      case (lp_state_r)
        rmcc_pkg::RMCC_LP_IDLE:  if (|comm_ctrl_r[2:0]) lp_state_r <= rmcc_pkg::RMCC_LP_ARMED;
        rmcc_pkg::RMCC_LP_ARMED: if (~|comm_ctrl_r[2:0]) lp_state_r <= rmcc_pkg::RMCC_LP_IDLE;
        default:                 lp_state_r <= rmcc_pkg::RMCC_LP_IDLE;
      endcase
    end
  end

endmodule : rmcc_top

// ### test/rmcc_checker.sv
// concurrent assertions for the rmcc register bank
`timescale 1ns/1ps
module rmcc_checker (
  input wire logic                   ref_clk,                       // clock
  input wire logic                   arst_n,                        // reset
  input wire rmcc_pkg::rmcc_req_t    reg_req,                       // request
  input wire logic [7:0]             reg_rdata,                     // read data
  input wire logic                   reg_rvalid,                    // read valid
  input wire rmcc_pkg::rmcc_events_t res_event,                     // events
  input wire logic                   event_clear,                   // clear
  input wire logic                   flag_source,                   // flag
  input wire logic                   irq_output_pin_n,              // irq pin
  input wire logic                   switch_pump_force_on,          // pump
  input wire logic                   internal_supply_force_battery, // supply
  input wire logic                   low_power_dual_role_request,   // drp pulse
  input wire logic                   low_power_upstream_request,    // ufp pulse
  input wire logic                   shutdown_request               // shutdown pulse
);
  logic       ctrl_wr;
  logic [2:0] trig;
  assign ctrl_wr = reg_req.wr_en && reg_req.addr == rmcc_pkg::COMM_CTRL_OFS;
  assign trig    = ctrl_wr ? reg_req.wdata[2:0] : 3'h0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ***********************************************
  // properties
  // ***********************************************
  sequence s_clear_quiet;
    event_clear && res_event == '0 && !flag_source ##1 !flag_source;
  endsequence
  property p_trig(logic s, logic t);
    s == $past(t);
  endproperty
  a_read_valid: assert property (reg_req.rd_en |=> reg_rvalid)
    else $error("read valid missing");
  a_no_stray_valid: assert property (!reg_req.rd_en |=> !reg_rvalid)
    else $error("read valid without read");
  a_rdata_holds: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_reserved_zero: assert property (reg_req.rd_en && reg_req.addr == rmcc_pkg::RES_MASK_OFS |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved mask bits read nonzero");
  a_shutdown_pulse: assert property (p_trig(shutdown_request, trig[0]))
    else $error("shutdown pulse wrong");
  a_lp_ufp_pulse: assert property (p_trig(low_power_upstream_request, trig[1]))
    else $error("upstream pulse wrong");
  a_lp_drp_pulse: assert property (p_trig(low_power_dual_role_request, trig[2]))
    else $error("dual role pulse wrong");
  a_pump_steady: assert property (!ctrl_wr [*3] |=> $stable(switch_pump_force_on))
    else $error("pump changed without write");
  a_supply_steady: assert property (!ctrl_wr [*3] |=> $stable(internal_supply_force_battery))
    else $error("supply changed without write");
  a_irq_clear: assert property (s_clear_quiet |=> irq_output_pin_n)
    else $error("irq pin low after clear");
endmodule : rmcc_checker

// ### test/tb.sv
// self-checking bench for the rmcc register bank
`timescale 1ns/1ps
module tb;
  logic                   ref_clk = 1'b0;
  logic                   arst_n = 1'b0;
  rmcc_pkg::rmcc_req_t    req = '0;
  rmcc_pkg::rmcc_events_t ev = '0;
  logic                   clr = 1'b0, flag = 1'b0, usb = 1'b0, dbg = 1'b0;
  logic [7:0]             rdata, d, v;
  logic                   rvalid, pin_n, auto, pump, supply;
  logic [2:0]             lp;
  int                     miscompares = 0, num_checks = 0, n_auto = 0, n0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (auto === 1'b1) n_auto++;
  rmcc_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .res_event(ev), .event_clear(clr), .flag_source(flag), .usb_valid(usb), .debug_sink_entered(dbg),
    .irq_output_pin_n(pin_n), .autocfg_start(auto), .switch_pump_force_on(pump),
    .internal_supply_force_battery(supply), .low_power_dual_role_request(lp[2]),
    .low_power_upstream_request(lp[1]), .shutdown_request(lp[0]));
  function automatic logic [7:0] mask_of(logic [7:0] x);
    return x & 8'h3f;
  endfunction : mask_of
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, x};
    @(posedge ref_clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) req <= '0;
    @(negedge ref_clk) d = rdata;
    chk("rvalid", 8'h01, {7'h0, rvalid});
  endtask : rd
  task automatic evt(input logic [5:0] e, input logic c);
    @(posedge ref_clk) begin ev <= rmcc_pkg::rmcc_events_t'(e); clr <= c; end
    @(posedge ref_clk) begin ev <= '0; clr <= 1'b0; end
    step(2);
  endtask : evt
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    #(50 * 5000);
    miscompares++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h1aff));
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(8'h11); chk("mask", 8'h00, d);
    rd(8'h15); chk("ctrl", 8'he0, d);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      wr(8'h11, v); rd(8'h11); chk("mask", mask_of(v), d);
      wr(8'h15, v);
      @(negedge ref_clk) chk("lp_pulse", {5'h0, v[2:0]}, {5'h0, lp});
      step(2); chk("pump_supply", {6'h0, v[4:3]}, {6'h0, pump, supply});
      rd(8'h15); chk("ctrl", v, d);
    end
    wr(8'h12, 8'hff); rd(8'h12); chk("unmapped", 8'h00, d);
    $display("register test done");
    wr(8'h15, 8'he0);
    for (int i = 0; i < 6; i++) begin
      wr(8'h11, 8'h01 << i); evt(6'h00, 1'b1);
      evt(~(6'h01 << i), 1'b0); chk("irq_masked", 8'h01, {7'h0, pin_n});
      evt(6'h01 << i, 1'b0); chk("irq_unmasked", 8'h00, {7'h0, pin_n});
      evt(6'h00, 1'b1); chk("irq_cleared", 8'h01, {7'h0, pin_n});
    end
    evt(6'h20, 1'b0); wr(8'h15, 8'h60); step(2); chk("flag_low", 8'h01, {7'h0, pin_n});
    @(posedge ref_clk) flag <= 1'b1;
    step(2); chk("flag_high", 8'h00, {7'h0, pin_n});
    @(posedge ref_clk) flag <= 1'b0;
    wr(8'h15, 8'he0); step(2); chk("irq_mode", 8'h00, {7'h0, pin_n});
    $display("irq test done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h15, k[0] ? 8'he0 : 8'h80);
      n0 = n_auto;
      @(posedge ref_clk) begin usb <= ~k[1]; dbg <= k[1]; end
      @(posedge ref_clk) dbg <= 1'b0;
      step(4); chk("autocfg", 8'(k[0]), 8'(n_auto - n0));
      @(posedge ref_clk) usb <= 1'b0;
    end
    $display("autocfg test done");
    report_and_stop;
  end
endmodule : tb
bind rmcc_top rmcc_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .res_event(res_event), .event_clear(event_clear), .flag_source(flag_source),
  .irq_output_pin_n(irq_output_pin_n), .switch_pump_force_on(switch_pump_force_on),
  .internal_supply_force_battery(internal_supply_force_battery),
  .low_power_dual_role_request(low_power_dual_role_request),
  .low_power_upstream_request(low_power_upstream_request), .shutdown_request(shutdown_request));
